// ### rtl/pfm_consts.svh
// Constants of the pin function override multiplexer: offsets, fields,
// reset values, fixed pin positions and timing counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define PFM_LINES 44
`define PFM_PORTB_LINES 12
`define PFM_TRACE_SLOTS 11

// ----------------------------------------------------------------------
// Register byte offsets (a = port A word, b = port B word)
// ----------------------------------------------------------------------
`define PFM_OFS_GPIO_EN_A 6'h00
`define PFM_OFS_GPIO_EN_B 6'h04
`define PFM_OFS_FSEL0_A 6'h08
`define PFM_OFS_FSEL0_B 6'h0c
`define PFM_OFS_FSEL1_A 6'h10
`define PFM_OFS_FSEL1_B 6'h14
`define PFM_OFS_OUT_A 6'h18
`define PFM_OFS_OUT_B 6'h1c
`define PFM_OFS_OE_A 6'h20
`define PFM_OFS_OE_B 6'h24
`define PFM_OFS_PULL_A 6'h28
`define PFM_OFS_PULL_B 6'h2c
`define PFM_OFS_PIN_A 6'h30
`define PFM_OFS_PIN_B 6'h34
`define PFM_OFS_TRACE_CTRL 6'h38
`define PFM_OFS_STATUS 6'h3c

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define PFM_TRACE_EN_BIT 0
`define PFM_TRACE_MAP_BIT 1
`define PFM_ST_TEST_BIT 0
`define PFM_ST_TRACE_BIT 1
`define PFM_ST_OSC0_BIT 2
`define PFM_ST_OSC1_BIT 3
`define PFM_ST_SLOW_BIT 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PFM_RST_GPIO_EN 44'hfff_ffff_ffff
`define PFM_RST_FSEL 44'h000_0000_0000
`define PFM_RST_OUT 44'h000_0000_0000
`define PFM_RST_OE 44'h000_0000_0000
`define PFM_RST_PULL 44'h000_0000_0000
`define PFM_RST_TRACE_CTRL 2'h0

// ----------------------------------------------------------------------
// Fixed pin positions (line index, port B starts at 32)
// ----------------------------------------------------------------------
`define PFM_TDI_LINE 0
`define PFM_TDO_LINE 1
`define PFM_TMS_LINE 2
`define PFM_TWI_SCL_LINE 9
`define PFM_TWI_SDA_LINE 10
`define PFM_SLOW_IN_LINE 11
`define PFM_SLOW_OUT_LINE 12
`define PFM_OSC0_IN_LINE 18
`define PFM_OSC0_OUT_LINE 19
`define PFM_OSC1_IN_LINE 28
`define PFM_OSC1_OUT_LINE 29
// Trace slots: 0 event in, 1..6 data 5..0, 7 event out, 8 clock,
// 9 frame control 1, 10 frame control 0; six bits each, map 0 then map 1
`define PFM_TRACE_MAP0 {6'h25, 6'h24, 6'h23, 6'h22, 6'h21, 6'h20, \
  6'h1f, 6'h0f, 6'h1e, 6'h26, 6'h27}
`define PFM_TRACE_MAP1 {6'h0e, 6'h08, 6'h07, 6'h06, 6'h05, 6'h04, \
  6'h03, 6'h0f, 6'h0d, 6'h09, 6'h0a}

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PFM_CLK_MHZ 10
`define PFM_SPIKE_NS 200
`define PFM_SPIKE_CYC ((`PFM_SPIKE_NS * `PFM_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/pfm_pkg.sv
// Types shared by the pin function override multiplexer.
// Assumes pfm_consts.svh on the include path.
`include "pfm_consts.svh"

package pfm_pkg;

  typedef logic [`PFM_LINES-1:0] pfm_lines_t;

  typedef enum logic [1:0] {
    PFM_FUNC_A = 2'h0,
    PFM_FUNC_B = 2'h1,
    PFM_FUNC_C = 2'h2,
    PFM_FUNC_D = 2'h3
  } pfm_func_e;

  typedef enum logic [2:0] {
    PFM_OWN_GPIO = 3'h0,
    PFM_OWN_FUNC = 3'h1,
    PFM_OWN_OSC = 3'h2,
    PFM_OWN_TRACE = 3'h3,
    PFM_OWN_TEST = 3'h4
  } pfm_owner_e;

endpackage : pfm_pkg

// ### rtl/pfm_sync.sv
// Three-stage input synchroniser for pins.
// Assumes inputs asynchronous to pclk; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps

module pfm_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] reset_val,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic primed;

  // Stages keep tracking the pins through reset, so the first compare
  // after release sees real levels rather than a false agreement on zero
  always_ff @(posedge pclk) begin
    stage1 <= async_in;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // Reset level is a port, so it is loaded by a clocked step, not the reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (!primed) begin
      sync_out <= reset_val;
    end else begin
      sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
    end
  end

endmodule : pfm_sync

// ### rtl/pfm_spike_filter.sv
// Spike filter for the two-wire bus lines.
// Assumes synchronised inputs; a level must hold PFM_SPIKE_CYC cycles to pass.
`timescale 1ns/1ps
`include "pfm_consts.svh"

module pfm_spike_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] raw_in,
  output logic [1:0] clean_out
);
  localparam logic [3:0] HOLD = 4'(`PFM_SPIKE_CYC);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bit
      logic [3:0] count;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          count <= 4'h0;
          clean_out[g] <= 1'b1;
        end else if (raw_in[g] == clean_out[g]) begin
          count <= 4'h0;
        end else if (count + 4'h1 >= HOLD) begin
          count <= 4'h0;
          clean_out[g] <= raw_in[g];
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  endgenerate

endmodule : pfm_spike_filter

// ### rtl/pfm_mux.sv
// Pin function override multiplexer: routes 44 port lines to GPIO or to one
// of four peripheral functions, with test port, trace and oscillator overrides.
// Assumes an APB master on pclk; pins asynchronous; power manager on pclk.
// Function
// - Each line selects GPIO or one of four peripheral functions A to D.
// - Enabled test port takes its fixed pins over any selected function.
// - Test port is enabled while the test clock pin is held low.
// - Test mode, data in, data out pins also GPIO; GPIO after reset.
// - Test clock pin is never a general I/O line.
// - Enabled trace takes its pins over the port function selection.
// - Map bit picks trace pin placement, 0 port B based, 1 port A based.
// - Oscillator pads are steered only by power manager controls.
// - Oscillators use lines 18/19, 28/29 and 11/12, input then output.
// - Every line has its own independently programmed pull-up enable.
// - After reset every line is input with pull-up off, unless preset.
// - Two-wire bus pins drive low only and filter spikes when selected.
// - External reset pin has a permanent pull-up; power-on reset suffices.
`timescale 1ns/1ps
`include "pfm_consts.svh"

module pfm_mux
  import pfm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [43:0] line_in,
  output logic [43:0] line_out,
  output logic [43:0] line_oe,
  output logic [43:0] line_pullup,
  output logic [43:0] line_analog,
  input wire logic test_clock_pin,
  output logic test_port_enabled,
  output logic test_data_in,
  output logic test_mode_select,
  input wire logic test_data_out,
  input wire logic [5:0] trace_data_out,
  input wire logic [1:0] trace_frame_control,
  input wire logic trace_clock_out,
  input wire logic debug_event_out_n,
  output logic debug_event_in_n,
  input wire logic pm_osc_zero_en,
  input wire logic pm_osc_one_en,
  input wire logic pm_slow_osc_en,
  input wire logic [43:0] func_a_out,
  input wire logic [43:0] func_a_oe,
  input wire logic [43:0] func_b_out,
  input wire logic [43:0] func_b_oe,
  input wire logic [43:0] func_c_out,
  input wire logic [43:0] func_c_oe,
  input wire logic [43:0] func_d_out,
  input wire logic [43:0] func_d_oe,
  output logic [43:0] line_to_periph,
  output logic reset_pin_pullup
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [5:0] trace_line(input logic map, input int slot);
    logic [65:0] table_bits;
    table_bits = map ? `PFM_TRACE_MAP1 : `PFM_TRACE_MAP0;
    return table_bits[(`PFM_TRACE_SLOTS-1-slot)*6 +: 6];
  endfunction : trace_line

  function automatic logic pick4(input pfm_func_e sel, input logic a, input logic b,
                                 input logic c, input logic d);
    case (sel)
      PFM_FUNC_A: return a;
      PFM_FUNC_B: return b;
      PFM_FUNC_C: return c;
      default: return d;
    endcase
  endfunction : pick4

  function automatic logic is_test_line(input int i);
    return i == `PFM_TDI_LINE || i == `PFM_TDO_LINE || i == `PFM_TMS_LINE;
  endfunction : is_test_line

  function automatic logic is_twi_line(input int i);
    return i == `PFM_TWI_SCL_LINE || i == `PFM_TWI_SDA_LINE;
  endfunction : is_twi_line

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  pfm_lines_t gpio_en;
  pfm_lines_t fsel0;
  pfm_lines_t fsel1;
  pfm_lines_t gpio_out;
  pfm_lines_t gpio_oe;
  pfm_lines_t pull_en;
  logic trace_enable;
  logic trace_map_select;

  logic wr_en;
  logic rd_setup;
  logic [5:0] ofs;
  logic mapped;

  assign ofs = paddr[5:0];
  assign mapped = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable;
  // Zero wait states keeps the bus simple; reads are prepared in setup
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign reset_pin_pullup = 1'b1;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_en <= `PFM_RST_GPIO_EN;
    end else if (wr_en && ofs == `PFM_OFS_GPIO_EN_A) begin
      gpio_en[31:0] <= pwdata;
    end else if (wr_en && ofs == `PFM_OFS_GPIO_EN_B) begin
      gpio_en[43:32] <= pwdata[11:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel0 <= `PFM_RST_FSEL;
      fsel1 <= `PFM_RST_FSEL;
    end else if (wr_en) begin
      case (ofs)
        `PFM_OFS_FSEL0_A: fsel0[31:0] <= pwdata;
        `PFM_OFS_FSEL0_B: fsel0[43:32] <= pwdata[11:0];
        `PFM_OFS_FSEL1_A: fsel1[31:0] <= pwdata;
        `PFM_OFS_FSEL1_B: fsel1[43:32] <= pwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out <= `PFM_RST_OUT;
      gpio_oe <= `PFM_RST_OE;
    end else if (wr_en) begin
      case (ofs)
        `PFM_OFS_OUT_A: gpio_out[31:0] <= pwdata;
        `PFM_OFS_OUT_B: gpio_out[43:32] <= pwdata[11:0];
        `PFM_OFS_OE_A: gpio_oe[31:0] <= pwdata;
        `PFM_OFS_OE_B: gpio_oe[43:32] <= pwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_en <= `PFM_RST_PULL;
    end else if (wr_en && ofs == `PFM_OFS_PULL_A) begin
      pull_en[31:0] <= pwdata;
    end else if (wr_en && ofs == `PFM_OFS_PULL_B) begin
      pull_en[43:32] <= pwdata[11:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_enable <= 1'(`PFM_RST_TRACE_CTRL >> `PFM_TRACE_EN_BIT);
      trace_map_select <= 1'b0;
    end else if (wr_en && ofs == `PFM_OFS_TRACE_CTRL) begin
      trace_enable <= pwdata[`PFM_TRACE_EN_BIT];
      trace_map_select <= pwdata[`PFM_TRACE_MAP_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------------
  pfm_lines_t pin_sync;
  logic tck_sync;
  logic [1:0] twi_clean;

  pfm_sync #(.W(45)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({test_clock_pin, line_in}),
    .reset_val({1'b1, 44'h000_0000_0000}),
    .sync_out({tck_sync, pin_sync})
  );

  pfm_spike_filter u_twi_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in({pin_sync[`PFM_TWI_SDA_LINE], pin_sync[`PFM_TWI_SCL_LINE]}),
    .clean_out(twi_clean)
  );

  // Test clock pin is sensed only, never muxed onto a port line
  logic test_owns;
  assign test_owns = !tck_sync;

  // ----------------------------------------------------------------------
  // Trace and oscillator claims
  // ----------------------------------------------------------------------
  pfm_lines_t trace_claim;
  pfm_lines_t trace_drive;
  pfm_lines_t trace_val;
  pfm_lines_t osc_claim;
  logic [10:0] trace_src;
  logic [5:0] evti_line;

  assign trace_src = {1'b1, trace_data_out[5], trace_data_out[4], trace_data_out[3],
                      trace_data_out[2], trace_data_out[1], trace_data_out[0],
                      debug_event_out_n, trace_clock_out,
                      trace_frame_control[1], trace_frame_control[0]};
  assign evti_line = trace_line(trace_map_select, 0);

  always_comb begin
    logic [5:0] ln;
    ln = 6'h0;
    trace_claim = '0;
    trace_drive = '0;
    trace_val = '0;
    if (trace_enable) begin
      for (int s = 0; s < `PFM_TRACE_SLOTS; s++) begin
        ln = trace_line(trace_map_select, s);
        trace_claim[ln] = 1'b1;
        trace_drive[ln] = (s != 0);
        trace_val[ln] = trace_src[`PFM_TRACE_SLOTS-1-s];
      end
    end
  end

  always_comb begin
    osc_claim = '0;
    // Pads are claimed only from the power manager, never from fsel
    osc_claim[`PFM_OSC0_IN_LINE] = pm_osc_zero_en;
    osc_claim[`PFM_OSC0_OUT_LINE] = pm_osc_zero_en;
    osc_claim[`PFM_OSC1_IN_LINE] = pm_osc_one_en;
    osc_claim[`PFM_OSC1_OUT_LINE] = pm_osc_one_en;
    osc_claim[`PFM_SLOW_IN_LINE] = pm_slow_osc_en;
    osc_claim[`PFM_SLOW_OUT_LINE] = pm_slow_osc_en;
  end

  // ----------------------------------------------------------------------
  // Per-line ownership and drive
  // ----------------------------------------------------------------------
  pfm_lines_t next_out;
  pfm_lines_t next_oe;
  pfm_lines_t next_pull;
  pfm_owner_e owner [`PFM_LINES];

  genvar i;
  generate
    for (i = 0; i < `PFM_LINES; i++) begin : g_line
      pfm_func_e sel;
      logic fo;
      logic fe;
      assign sel = pfm_func_e'({fsel1[i], fsel0[i]});
      assign fo = pick4(sel, func_a_out[i], func_b_out[i], func_c_out[i], func_d_out[i]);
      assign fe = pick4(sel, func_a_oe[i], func_b_oe[i], func_c_oe[i], func_d_oe[i]);

      always_comb begin
        if (test_owns && is_test_line(i)) begin
          owner[i] = PFM_OWN_TEST;
        end else if (trace_claim[i]) begin
          owner[i] = PFM_OWN_TRACE;
        end else if (osc_claim[i]) begin
          owner[i] = PFM_OWN_OSC;
        end else if (gpio_en[i]) begin
          owner[i] = PFM_OWN_GPIO;
        end else begin
          owner[i] = PFM_OWN_FUNC;
        end
      end

      always_comb begin
        next_out[i] = 1'b0;
        next_oe[i] = 1'b0;
        next_pull[i] = pull_en[i];
        case (owner[i])
          PFM_OWN_TEST: begin
            next_out[i] = test_data_out;
            next_oe[i] = (i == `PFM_TDO_LINE);
            // Mode select and data in keep their pull-ups while owned
            next_pull[i] = (i != `PFM_TDO_LINE);
          end
          PFM_OWN_TRACE: begin
            next_out[i] = trace_val[i];
            next_oe[i] = trace_drive[i];
          end
          PFM_OWN_OSC: begin
            next_pull[i] = 1'b0;
          end
          PFM_OWN_GPIO: begin
            next_out[i] = gpio_out[i];
            next_oe[i] = gpio_oe[i];
          end
          PFM_OWN_FUNC: begin
            if (is_twi_line(i) && sel == PFM_FUNC_A) begin
              // Open drain: only ever pull low
              next_out[i] = 1'b0;
              next_oe[i] = fe && !fo;
            end else begin
              next_out[i] = fo;
              next_oe[i] = fe;
            end
          end
          default: begin
          end
        endcase
      end

      always_comb begin
        if (is_twi_line(i) && owner[i] == PFM_OWN_FUNC && sel == PFM_FUNC_A) begin
          line_to_periph[i] = (i == `PFM_TWI_SCL_LINE) ? twi_clean[0] : twi_clean[1];
        end else begin
          line_to_periph[i] = pin_sync[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Registered pad controls
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_out <= '0;
      line_oe <= '0;
      line_pullup <= `PFM_RST_PULL;
      line_analog <= '0;
    end else begin
      line_out <= next_out;
      line_oe <= next_oe;
      line_pullup <= next_pull;
      line_analog <= osc_claim & ~trace_claim;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_port_enabled <= 1'b0;
      test_data_in <= 1'b1;
      test_mode_select <= 1'b1;
      debug_event_in_n <= 1'b1;
    end else begin
      test_port_enabled <= test_owns;
      // Idle high keeps the test state machine parked when not owned
      test_data_in <= test_owns ? pin_sync[`PFM_TDI_LINE] : 1'b1;
      test_mode_select <= test_owns ? pin_sync[`PFM_TMS_LINE] : 1'b1;
      debug_event_in_n <= (trace_enable && owner[evti_line] == PFM_OWN_TRACE) ?
                          pin_sync[evti_line] : 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup && !pwrite) begin
      case (ofs)
        `PFM_OFS_GPIO_EN_A: prdata <= gpio_en[31:0];
        `PFM_OFS_GPIO_EN_B: prdata <= {20'h0_0000, gpio_en[43:32]};
        `PFM_OFS_FSEL0_A: prdata <= fsel0[31:0];
        `PFM_OFS_FSEL0_B: prdata <= {20'h0_0000, fsel0[43:32]};
        `PFM_OFS_FSEL1_A: prdata <= fsel1[31:0];
        `PFM_OFS_FSEL1_B: prdata <= {20'h0_0000, fsel1[43:32]};
        `PFM_OFS_OUT_A: prdata <= gpio_out[31:0];
        `PFM_OFS_OUT_B: prdata <= {20'h0_0000, gpio_out[43:32]};
        `PFM_OFS_OE_A: prdata <= gpio_oe[31:0];
        `PFM_OFS_OE_B: prdata <= {20'h0_0000, gpio_oe[43:32]};
        `PFM_OFS_PULL_A: prdata <= pull_en[31:0];
        `PFM_OFS_PULL_B: prdata <= {20'h0_0000, pull_en[43:32]};
        `PFM_OFS_PIN_A: prdata <= pin_sync[31:0];
        `PFM_OFS_PIN_B: prdata <= {20'h0_0000, pin_sync[43:32]};
        `PFM_OFS_TRACE_CTRL: prdata <= {30'h0, trace_map_select, trace_enable};
        `PFM_OFS_STATUS: prdata <= {27'h0, pm_slow_osc_en, pm_osc_one_en,
                                    pm_osc_zero_en, trace_enable, test_owns};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : pfm_mux

// ### bench/pfm_probe.sv
// Far-side model: debug probe on the test clock pin and pad wiring.
// Assumes the bench drives ext as the level of pads nobody drives.
`timescale 1ns/1ps

module pfm_probe (
  input wire logic pclk,
  input wire logic tck_low,
  input wire logic [43:0] ext,
  input wire logic [43:0] line_out,
  input wire logic [43:0] line_oe,
  input wire logic [43:0] line_pullup,
  output logic [43:0] line_in,
  output logic test_clock_pin
);
  // ----------------------------------------
  // Probe and pad levels
  // ----------------------------------------
  initial test_clock_pin = 1'b1;
  // Held low to claim the test port
  always @(posedge pclk) test_clock_pin <= !tck_low;
  // Released pads fall to the pull-up, else to the outside level
  assign line_in = (line_oe & line_out) | (~line_oe & (line_pullup | ext));
endmodule : pfm_probe

// ### bench/pfm_mux_asserts.sv
// Port checker for the pin multiplexer.
// Assumes binding into pfm_mux; one clock domain.
`timescale 1ns/1ps

module pfm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [43:0] line_out,
  input wire logic [43:0] line_oe,
  input wire logic [43:0] line_pullup,
  input wire logic [43:0] line_analog,
  input wire logic test_clock_pin,
  input wire logic test_port_enabled,
  input wire logic test_data_in,
  input wire logic test_mode_select,
  input wire logic test_data_out,
  input wire logic pm_osc_zero_en,
  input wire logic pm_osc_one_en,
  input wire logic pm_slow_osc_en,
  input wire logic reset_pin_pullup
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_tck_low;
    $fell(test_clock_pin) ##1 (!test_clock_pin)[*6];
  endsequence
  sequence s_owned;
    test_port_enabled && $past(test_port_enabled);
  endsequence
  AST_TCK_ON: assert property (s_tck_low |-> test_port_enabled)
    else $error("test port not taken");
  AST_TCK_OFF: assert property (test_clock_pin[*8] |-> !test_port_enabled)
    else $error("test port held without pin");
  AST_TDO: assert property (s_owned |->
    line_oe[1] && line_out[1] == $past(test_data_out))
    else $error("test data out not driven");
  AST_TPINS: assert property (s_owned |->
    !line_oe[0] && !line_oe[2] && line_pullup[0] && line_pullup[2])
    else $error("test input pins wrong");
  AST_TIDLE: assert property (!test_port_enabled &&
    !$past(test_port_enabled) |-> test_data_in && test_mode_select)
    else $error("test inputs not idle");
  AST_ANALOG: assert property (line_analog ==
    (({44{$past(pm_osc_zero_en)}} & 44'h000_000c_0000) |
    ({44{$past(pm_osc_one_en)}} & 44'h000_3000_0000) |
    ({44{$past(pm_slow_osc_en)}} & 44'h000_0000_1800)))
    else $error("oscillator pads wrong");
  AST_SLOWPAD: assert property ($past(pm_slow_osc_en) |->
    line_oe[12:11] == 2'h0 && line_pullup[12:11] == 2'h0)
    else $error("slow oscillator pads driven");
  AST_RSTIDLE: assert property ($rose(presetn) |->
    line_oe == 44'h0 && line_pullup == 44'h0)
    else $error("pads not idle after reset");
  AST_RSTPIN: assert property (reset_pin_pullup)
    else $error("reset pin pull-up off");
endmodule : pfm_chk

bind pfm_mux pfm_chk i_chk (.pclk, .presetn, .line_out, .line_oe, .line_pullup, .line_analog,
  .test_clock_pin, .test_port_enabled, .test_data_in, .test_mode_select, .test_data_out,
  .pm_osc_zero_en, .pm_osc_one_en, .pm_slow_osc_en, .reset_pin_pullup);

// ### bench/pin_function_override_mux_tb_top.sv
// Bench for the pin multiplexer: APB tasks and pad checks.
// Assumes the probe model and bound checker are compiled alongside.
`timescale 1ns/1ps
`include "pfm_consts.svh"

module pin_function_override_mux_tb_top;
  import pfm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, test_port_enabled, test_data_in, test_mode_select;
  logic debug_event_in_n, reset_pin_pullup, test_clock_pin, tck_low = 1'b0;
  logic test_data_out = 1'b0, trace_clock_out = 1'b1, debug_event_out_n = 1'b1;
  logic pm_osc_zero_en = 1'b0, pm_osc_one_en = 1'b0, pm_slow_osc_en = 1'b0;
  logic [5:0] trace_data_out = 6'h2a;
  logic [1:0] trace_frame_control = 2'h0;
  logic [43:0] line_in, line_out, line_oe, line_pullup, line_analog, line_to_periph;
  logic [43:0] ext = 44'h0, func_a_out = 44'h000_0000_0200, func_a_oe = 44'hfff_ffff_ffff;
  logic [43:0] func_b_out = 44'hfff_ffff_ffff, func_b_oe = 44'hfff_ffff_ffff;
  logic [43:0] func_c_out = 44'h0, func_c_oe = 44'h0;
  logic [43:0] func_d_out = 44'hfff_ffff_ffff, func_d_oe = 44'h0;
  int bad_count = 0, tests_run = 0;
  always #50 pclk = ~pclk;

  pfm_mux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .line_in, .line_out, .line_oe, .line_pullup, .line_analog, .test_clock_pin,
    .test_port_enabled, .test_data_in, .test_mode_select, .test_data_out, .trace_data_out,
    .trace_frame_control, .trace_clock_out, .debug_event_out_n, .debug_event_in_n,
    .pm_osc_zero_en, .pm_osc_one_en, .pm_slow_osc_en, .func_a_out, .func_a_oe, .func_b_out,
    .func_b_oe, .func_c_out, .func_c_oe, .func_d_out, .func_d_oe, .line_to_periph,
    .reset_pin_pullup);
  pfm_probe i_probe (.pclk, .tck_low, .ext, .line_out, .line_oe, .line_pullup, .line_in,
    .test_clock_pin);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk({r, e}, {exp, err});
  endtask : rdc
  // Margin covers the pin synchroniser and ownership register
  task automatic settle;
    repeat (12) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task automatic tend(input string name);
    $display("test %s done", name);
  endtask : tend
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk(line_oe | line_pullup, 44'h0);
    rdc(`PFM_OFS_GPIO_EN_A, 32'hffff_ffff, 1'b0);
    rdc(`PFM_OFS_GPIO_EN_B, 32'h0000_0fff, 1'b0);
    rdc(`PFM_OFS_PULL_A, 32'h0, 1'b0);
    rdc(32'h40, 32'hffff_ffff, 1'b1);
    tend("reset");
    wr(`PFM_OFS_PULL_A, 32'h0000_0005);
    wr(`PFM_OFS_PULL_B, 32'h0000_0802);
    settle;
    chk(line_pullup, 44'h802_0000_0005);
    tend("pullup");
    wr(`PFM_OFS_GPIO_EN_A, 32'hffef_fdff);
    for (int f = 0; f < 4; f++) begin
      wr(`PFM_OFS_FSEL0_A, {32{f[0]}});
      wr(`PFM_OFS_FSEL1_A, {32{f[1]}});
      settle;
      chk({line_out[20], line_oe[20]}, {f[0], !f[1]});
      if (f < 2) chk({line_out[9], line_oe[9]}, {f[0], f[0]});
    end
    tend("function");
    wr(`PFM_OFS_GPIO_EN_A, 32'hffff_ffff);
    wr(`PFM_OFS_OE_A, 32'hffff_ffff);
    wr(`PFM_OFS_OE_B, 32'h0000_0fff);
    wr(`PFM_OFS_TRACE_CTRL, 32'h1);
    settle;
    chk(line_out[36:30], 7'h55);
    chk(debug_event_in_n, 1'b0);
    wr(`PFM_OFS_TRACE_CTRL, 32'h3);
    settle;
    chk({line_out[13], line_out[8:3], line_out[36:30]}, {1'b1, 6'h2a, 7'h00});
    wr(`PFM_OFS_TRACE_CTRL, 32'h0);
    tend("trace");
    @(posedge pclk);
    test_data_out <= 1'b1;
    tck_low <= 1'b1;
    settle;
    chk({test_port_enabled, line_oe[1], line_out[1]}, 3'h7);
    @(posedge pclk);
    tck_low <= 1'b0;
    settle;
    chk({test_port_enabled, line_oe[1], line_out[1]}, 3'h2);
    tend("test port");
    @(posedge pclk);
    pm_osc_zero_en <= 1'b1;
    pm_osc_one_en <= 1'b1;
    pm_slow_osc_en <= 1'b1;
    settle;
    chk(line_analog, 44'h000_300c_1800);
    chk(line_oe[29:28], 2'h0);
    tend("oscillator");
    results();
  end

  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule : pin_function_override_mux_tb_top
